/* File: include/uvd_regs.svh */
`ifndef UVD_REGS_SVH
`define UVD_REGS_SVH

// ===========================================================================
// Register offsets (byte addresses).
`define UVD_OFS_RSVD 8'h00
`define UVD_OFS_CTRL 8'h04
`define UVD_OFS_EVT_STAT 8'h08
`define UVD_OFS_EVT_CLR 8'h0c
`define UVD_OFS_EVT_ENA 8'h10

// ===========================================================================
// Field positions and reset values.
`define UVD_CTRL_FLAG_BIT 7
`define UVD_CTRL_FIELD_W 7
`define UVD_CTRL_RST 7'h00
`define UVD_EVT_W 3
`define UVD_EVT_RST 3'h0
`define UVD_CODE_FIRST 3'h3

// ===========================================================================
// Bus answers.
`define UVD_RESP_OKAY 2'h0
`define UVD_RESP_SLVERR 2'h2

// ===========================================================================
// Detection interval.
`define UVD_DETECT_TIME_NS 100000
`define UVD_CLK_PERIOD_NS 25
`define UVD_DETECT_CYCLES \
    ((`UVD_DETECT_TIME_NS + `UVD_CLK_PERIOD_NS - 1) / `UVD_CLK_PERIOD_NS)
`define UVD_CNT_W 12

`endif

/* File: include/uvd_pkg.sv */
`include "uvd_regs.svh"
`default_nettype none

package uvd_pkg;

    typedef struct packed {
        logic rst_allow;
        logic irq_allow;
        logic irq_sel;
        logic [2:0] code;
        logic en;
    } uvd_ctrl_t;

    typedef struct packed {
        logic rst;
        logic rise;
        logic fall;
    } uvd_evt_t;

    typedef struct packed {
        logic ena;
        logic clr;
        logic stat;
        logic ctrl;
        logic rsvd;
    } uvd_sel_t;

    typedef enum logic [2:0] {
        DET_OFF = 3'b001,
        DET_HIGH = 3'b010,
        DET_LOW = 3'b100
    } uvd_det_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } uvd_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } uvd_axi_rsp_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } uvd_sync_t;

    typedef struct packed {
        logic [`UVD_CNT_W-1:0] cnt;
        logic level;
    } uvd_qual_t;

    typedef struct packed {
        uvd_ctrl_t ctrl;
        uvd_evt_t status;
        uvd_evt_t evt_en;
        uvd_det_e det;
        logic nmi;
        logic rst_req;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } uvd_state_t;

endpackage

`default_nettype wire

/* File: core/uvd_sync.sv */
`include "uvd_regs.svh"
`default_nettype none

module uvd_sync (
    input wire logic i_clk, // System clock.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_async, // Level from another timing domain.
    output logic o_sync // Level after two flip-flops.
);
    import uvd_pkg::*;

    uvd_sync_t s_q;
    uvd_sync_t s_d;

    always_comb begin
        s_d.meta = i_async;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.sync;

    property p_two_ff;
        @(posedge i_clk) disable iff (i_rst)
        !$past(i_rst) && !$past(i_rst, 2) |-> o_sync == $past(i_async, 2);
    endproperty
    a_two_ff: assert property (p_two_ff)
        else $error("Synchroniser output is not two cycles late.");

endmodule

`default_nettype wire

/* File: core/uvd_qual.sv */
`include "uvd_regs.svh"
`default_nettype none

module uvd_qual (
    input wire logic i_clk, // System clock.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_clr, // Hold the filter idle at low.
    input wire logic i_in, // Synchronised comparator level.
    output logic o_level // Level after the detection interval.
);
    import uvd_pkg::*;

    localparam logic [`UVD_CNT_W-1:0] CNT_LAST =
        `UVD_CNT_W'(`UVD_DETECT_CYCLES - 1);

    uvd_qual_t s_q;
    uvd_qual_t s_d;

    // A new level is taken only after it has stood for the whole interval.
    // Any return to the old level restarts the count, so chatter near the
    // threshold never passes.
    always_comb begin
        s_d = s_q;
        if (i_clr) begin
            s_d = '0;
        end else if (i_in == s_q.level) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == CNT_LAST) begin
            s_d.level = i_in;
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + `UVD_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.level;

    property p_settle;
        @(posedge i_clk) disable iff (i_rst)
        !i_clr && i_in != s_q.level && s_q.cnt == CNT_LAST
            |=> o_level == $past(i_in);
    endproperty
    a_settle: assert property (p_settle)
        else $error("Level not taken at the end of the interval.");

    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
        !i_clr && s_q.cnt != CNT_LAST |=> $stable(o_level);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Level changed before the interval ended.");

endmodule

`default_nettype wire

/* File: core/uvd_ctrl.sv */
// The AXI4-Lite slave port is this design's own decision.
`include "uvd_regs.svh"
`default_nettype none

// ===========================================================================
// Functional notes
// - Reset request when allowed, enabled and below.
// - Interrupt only with reset off, interrupt on.
// - Interrupt goes out as a non-maskable request.
// - Crossing select 0: interrupt on falling crossing.
// - Crossing select 1: interrupt on both crossings.
// - Bit 7 reads the live below-threshold flag.
// - Threshold code bits 3..1; codes below 011 reserved.
// - Detection needs valid code and enable bit 0.
// - Control register clears to zero on reset.
// - About 100 us from drop to reset request.
// - Short drops may give no reset request.
// - About 100 us from crossing to interrupt.
// - Repeated chatter near threshold is tolerated.
// - Control at 0x04, 0x00 reserved, upper bits zero.
module uvd_ctrl (
    input wire logic i_clk, // System clock, 40 MHz.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_cmp_below, // Raw comparator, high when below.
    input wire uvd_pkg::uvd_axi_req_t i_axi, // AXI4-Lite requests.
    output uvd_pkg::uvd_axi_rsp_t o_axi, // AXI4-Lite answers.
    output logic o_detect_en, // Comparator power-up.
    output logic [2:0] o_threshold_code, // Comparator level select.
    output logic o_reset_req, // System reset request, level.
    output logic o_undervoltage_irq, // Non-maskable request pulse.
    output logic o_irq // Maskable event interrupt, level.
);
    import uvd_pkg::*;

    // =======================================================================
    // Decoding helpers.
    function automatic uvd_sel_t f_decode(input logic [7:0] a);
        uvd_sel_t s;
        s = '0;
        s.rsvd = (a == `UVD_OFS_RSVD);
        s.ctrl = (a == `UVD_OFS_CTRL);
        s.stat = (a == `UVD_OFS_EVT_STAT);
        s.clr = (a == `UVD_OFS_EVT_CLR);
        s.ena = (a == `UVD_OFS_EVT_ENA);
        return s;
    endfunction

    function automatic logic f_code_ok(input logic [2:0] c);
        return c >= `UVD_CODE_FIRST;
    endfunction

    // =======================================================================
    // State.
    uvd_state_t s_q;
    uvd_state_t s_d;

    logic sync_below;
    logic filt_below;
    logic active;
    logic flag;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    uvd_sel_t wr_sel;
    uvd_sel_t rd_sel;
    uvd_evt_t evt;
    uvd_evt_t clr_bits;

    // =======================================================================
    // Comparator path.
    uvd_sync u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_cmp_below),
        .o_sync(sync_below)
    );

    uvd_qual u_qual (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(!active),
        .i_in(sync_below),
        .o_level(filt_below)
    );

    assign active = s_q.ctrl.en && f_code_ok(s_q.ctrl.code);
    assign flag = active && sync_below;

    // =======================================================================
    // Bus handshakes.
    assign aw_take = i_axi.awvalid && !s_q.aw_got && !s_q.bvalid;
    assign w_take = i_axi.wvalid && !s_q.w_got && !s_q.bvalid;
    assign ar_take = i_axi.arvalid && !s_q.rvalid;
    assign wr_go = (s_q.aw_got || aw_take) && (s_q.w_got || w_take);
    assign wr_addr = s_q.aw_got ? s_q.awaddr : i_axi.awaddr;
    assign wr_data = s_q.w_got ? s_q.wdata : i_axi.wdata;
    assign wr_strb = s_q.w_got ? s_q.wstrb : i_axi.wstrb;
    assign wr_sel = f_decode(wr_addr);
    assign rd_sel = f_decode(i_axi.araddr);

    // =======================================================================
    // Next state.
    always_comb begin
        s_d = s_q;
        s_d.nmi = 1'b0;
        evt = '0;
        clr_bits = '0;

        // Write address and data are taken in either order.
        if (aw_take && !wr_go) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = i_axi.awaddr;
        end
        if (w_take && !wr_go) begin
            s_d.w_got = 1'b1;
            s_d.wdata = i_axi.wdata;
            s_d.wstrb = i_axi.wstrb;
        end
        if (s_q.bvalid && i_axi.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `UVD_RESP_OKAY;
            if (wr_sel == '0) begin
                s_d.bresp = `UVD_RESP_SLVERR;
            end
            if (wr_strb[0]) begin
                if (wr_sel.ctrl) begin
                    s_d.ctrl = wr_data[`UVD_CTRL_FIELD_W-1:0];
                end
                if (wr_sel.ena) begin
                    s_d.evt_en = wr_data[`UVD_EVT_W-1:0];
                end
                if (wr_sel.clr) begin
                    clr_bits = wr_data[`UVD_EVT_W-1:0];
                end
            end
        end

        // Read channel; the clear register reads as zero.
        if (s_q.rvalid && i_axi.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_take) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `UVD_RESP_OKAY;
            s_d.rdata = '0;
            if (rd_sel.ctrl) begin
                s_d.rdata[`UVD_CTRL_FIELD_W-1:0] = s_q.ctrl;
                s_d.rdata[`UVD_CTRL_FLAG_BIT] = flag;
            end
            if (rd_sel.stat) begin
                s_d.rdata[`UVD_EVT_W-1:0] = s_q.status;
            end
            if (rd_sel.ena) begin
                s_d.rdata[`UVD_EVT_W-1:0] = s_q.evt_en;
            end
            if (rd_sel == '0) begin
                s_d.rresp = `UVD_RESP_SLVERR;
            end
        end

        // Crossing tracker on the filtered level.
        case (s_q.det)
            DET_OFF: begin
                if (active) begin
                    s_d.det = DET_HIGH;
                end
            end
            DET_HIGH: begin
                if (!active) begin
                    s_d.det = DET_OFF;
                end else if (filt_below) begin
                    s_d.det = DET_LOW;
                    evt.fall = 1'b1;
                end
            end
            DET_LOW: begin
                if (!active) begin
                    s_d.det = DET_OFF;
                end else if (!filt_below) begin
                    s_d.det = DET_HIGH;
                    evt.rise = 1'b1;
                end
            end
            default: begin
                s_d.det = DET_OFF;
            end
        endcase

        // Reset takes priority over the interrupt.
        s_d.rst_req = active && s_q.ctrl.rst_allow && filt_below;
        evt.rst = s_d.rst_req && !s_q.rst_req;
        if (!s_q.ctrl.rst_allow && s_q.ctrl.irq_allow) begin
            s_d.nmi = evt.fall
                || (evt.rise && s_q.ctrl.irq_sel);
        end

        // A new event wins over a clear in the same cycle.
        s_d.status = (s_q.status & ~clr_bits) | evt;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.det <= DET_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    // =======================================================================
    // Outputs.
    always_comb begin
        o_axi.awready = !s_q.aw_got && !s_q.bvalid;
        o_axi.wready = !s_q.w_got && !s_q.bvalid;
        o_axi.bvalid = s_q.bvalid;
        o_axi.bresp = s_q.bresp;
        o_axi.arready = !s_q.rvalid;
        o_axi.rvalid = s_q.rvalid;
        o_axi.rdata = s_q.rdata;
        o_axi.rresp = s_q.rresp;
    end

    assign o_detect_en = s_q.ctrl.en;
    assign o_threshold_code = s_q.ctrl.code;
    assign o_reset_req = s_q.rst_req;
    assign o_undervoltage_irq = s_q.nmi;
    assign o_irq = |(s_q.status & s_q.evt_en);

    // =======================================================================
    // Checks.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_fall_step;
        s_q.det == DET_HIGH ##1 s_q.det == DET_LOW;
    endsequence

    sequence s_rise_step;
        s_q.det == DET_LOW ##1 s_q.det == DET_HIGH;
    endsequence

    property p_reset_on;
        active && s_q.ctrl.rst_allow && filt_below |=> o_reset_req;
    endproperty
    a_reset_on: assert property (p_reset_on)
        else $error("Reset request missing while below.");

    property p_irq_gate;
        o_undervoltage_irq
            |-> $past(!s_q.ctrl.rst_allow && s_q.ctrl.irq_allow);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("Interrupt raised with wrong allow bits.");

    property p_fall_irq;
        (!s_q.ctrl.rst_allow && s_q.ctrl.irq_allow && active)
            ##0 s_fall_step |-> o_undervoltage_irq;
    endproperty
    a_fall_irq: assert property (p_fall_irq)
        else $error("Falling crossing gave no interrupt.");

    property p_rise_irq;
        (s_q.ctrl.irq_allow && !s_q.ctrl.rst_allow) ##0 s_rise_step
            |-> o_undervoltage_irq == $past(s_q.ctrl.irq_sel);
    endproperty
    a_rise_irq: assert property (p_rise_irq)
        else $error("Rising crossing interrupt wrong for select.");

    property p_flag_read;
        ar_take && rd_sel.ctrl |=> o_axi.rdata[7] == $past(flag)
            && o_axi.rdata[31:8] == 24'h000000;
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("Control read shows wrong flag or upper bits.");

    property p_code_gate;
        o_reset_req |-> $past(f_code_ok(s_q.ctrl.code) && s_q.ctrl.en);
    endproperty
    a_code_gate: assert property (p_code_gate)
        else $error("Reset request with detection not armed.");

    property p_reset_clear;
        $fell(i_rst) |-> s_q.ctrl == `UVD_CTRL_RST
            && !o_reset_req && !o_undervoltage_irq;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Control not cleared by reset.");

    property p_pulse;
        o_undervoltage_irq |=> !o_undervoltage_irq;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("Interrupt pulse longer than one cycle.");

    property p_quiet_off;
        !s_q.ctrl.en |=> !o_undervoltage_irq && !o_reset_req;
    endproperty
    a_quiet_off: assert property (p_quiet_off)
        else $error("Event produced while detection is off.");

    property p_rst_release;
        !filt_below |=> !o_reset_req;
    endproperty
    a_rst_release: assert property (p_rst_release)
        else $error("Reset request while not below.");

    property p_nmi_blocked;
        s_q.ctrl.rst_allow |=> !o_undervoltage_irq;
    endproperty
    a_nmi_blocked: assert property (p_nmi_blocked)
        else $error("Interrupt raised while reset is allowed.");

    property p_fall_only;
        s_q.det == DET_LOW && !filt_below && !s_q.ctrl.irq_sel
            |=> !o_undervoltage_irq;
    endproperty
    a_fall_only: assert property (p_fall_only)
        else $error("Rising crossing interrupted with select 0.");

    property p_filter_off;
        !active |=> !filt_below;
    endproperty
    a_filter_off: assert property (p_filter_off)
        else $error("Filtered level high while detection is off.");

    property p_ctrl_write;
        wr_go && wr_strb[0] && wr_sel.ctrl
            |=> s_q.ctrl == $past(wr_data[`UVD_CTRL_FIELD_W-1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Control write did not land.");

endmodule

`default_nettype wire

/* File: dv/uvd_cmp_model.sv */
`default_nettype none

// ===========================================================================
// Behavioural supply comparator at the far side of the detector.
module uvd_cmp_model (
    input wire logic [2:0] i_code, // Selected threshold code.
    input wire logic [11:0] i_supply_mv, // Supply level in millivolts.
    output logic o_below // High at or below the threshold.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] thr_mv;
    // Reserved codes still trip at some level, so the block must gate them.
    assign thr_mv = 12'h898 + 12'h064 * {9'h000, i_code};
    // A bare compare has no hysteresis, so chatter passes straight through.
    assign o_below = (i_supply_mv <= thr_mv);
endmodule

`default_nettype wire

/* File: dv/low_voltage_detect_control_tb_top.sv */
`include "uvd_regs.svh"
`default_nettype none

module low_voltage_detect_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import uvd_pkg::*;
    localparam logic [7:0] RSVD = `UVD_OFS_RSVD;
    localparam logic [7:0] CTRL = `UVD_OFS_CTRL;
    localparam logic [7:0] STAT = `UVD_OFS_EVT_STAT;
    localparam logic [7:0] CLR = `UVD_OFS_EVT_CLR;
    localparam logic [7:0] ENA = `UVD_OFS_EVT_ENA;
    localparam logic [1:0] OK = `UVD_RESP_OKAY;
    localparam logic [1:0] ERR = `UVD_RESP_SLVERR;
    localparam logic [11:0] HI = 12'hce4;
    localparam logic [11:0] LO = 12'h960;
    localparam logic [11:0] VLOW = 12'h7d0;
    localparam int DET = `UVD_DETECT_CYCLES;
    localparam int SETTLE = DET + 100;
    logic i_clk, i_rst, det_en, rst_req, nmi, irq, below, nmi_q;
    logic [2:0] code;
    logic [11:0] supply_mv;
    logic [31:0] seed, r, c;
    logic [31:0] rdq[$];
    logic [1:0] rrq[$];
    logic [1:0] bq[$];
    logic [31:0] inact[4] = '{32'h41, 32'h63, 32'h25, 32'h26};
    uvd_axi_req_t req;
    uvd_axi_rsp_t rsp;
    int failures = 0;
    int checks = 0;
    int nmi_cnt = 0;
    int long_cnt = 0;
    int k, lat;

    uvd_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_cmp_below(below),
        .i_axi(req), .o_axi(rsp), .o_detect_en(det_en),
        .o_threshold_code(code), .o_reset_req(rst_req),
        .o_undervoltage_irq(nmi), .o_irq(irq));
    uvd_cmp_model cmp (.i_code(code), .i_supply_mv(supply_mv),
        .o_below(below));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // =======================================================================
    // Helpers.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic supply(input logic [11:0] mv, input int n);
        supply_mv <= mv;
        tick(n);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] resp);
        logic aw, w;
        int n;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        bq.push_back(resp);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while ((aw || w) && n < 50) begin
            @(posedge i_clk);
            n++;
            if (aw && rsp.awready) begin
                aw = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready) begin
                w = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge i_clk);
            n++;
        end while (!rsp.bvalid && n < 50);
        req.bready <= 1'b0;
        @(posedge i_clk);
        check(n < 50, 1);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] resp);
        int n;
        n = 0;
        rdq.push_back(exp);
        rrq.push_back(resp);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (!rsp.arready && n < 50);
        req.arvalid <= 1'b0;
        do begin
            @(posedge i_clk);
            n++;
        end while (!rsp.rvalid && n < 50);
        req.rready <= 1'b0;
        @(posedge i_clk);
        check(n < 50, 1);
    endtask

    // =======================================================================
    // Output watcher: bus answers against the noted queue, pulse counts.
    always @(posedge i_clk) begin
        nmi_q <= nmi;
        if (!i_rst) begin
            if (nmi) nmi_cnt++;
            if (nmi && nmi_q) long_cnt++;
            if (rsp.rvalid && req.rready) begin
                check(rsp.rdata, rdq.pop_front());
                check({30'h0, rsp.rresp}, {30'h0, rrq.pop_front()});
            end
            if (rsp.bvalid && req.bready) begin
                check({30'h0, rsp.bresp}, {30'h0, bq.pop_front()});
            end
        end
    end

    initial begin
        repeat (90000) @(posedge i_clk);
        failures++;
        wrap_up();
    end

    // =======================================================================
    // Main sequence.
    initial begin
        seed = 32'he579;
        req = '0;
        supply_mv = HI;
        i_rst = 1'b1;
        tick(4);
        i_rst <= 1'b0;
        tick(1);
        axi_rd(CTRL, 32'h0, OK);
        axi_wr(RSVD, rnd(), OK);
        axi_rd(RSVD, 32'h0, OK);
        axi_rd(8'h40, 32'h0, ERR);
        r = rnd();
        axi_wr(CTRL, {r[31:8], 8'hff}, OK);
        axi_rd(CTRL, 32'h7f, OK);
        check(det_en, 1);
        check(code, 3'h7);
        i_rst <= 1'b1;
        tick(4);
        i_rst <= 1'b0;
        tick(1);
        axi_rd(CTRL, 32'h0, OK);
        k = nmi_cnt;
        foreach (inact[i]) begin
            axi_wr(CTRL, inact[i], OK);
            supply(VLOW, SETTLE);
            check(rst_req, 0);
            axi_rd(CTRL, inact[i], OK);
            supply(HI, 4);
        end
        check(nmi_cnt, k);
        axi_wr(CTRL, 32'h47, OK);
        r = rnd();
        supply(LO, int'(r[10:0]) + 500);
        supply(HI, SETTLE);
        check(rst_req, 0);
        supply(LO, 1);
        lat = 1;
        while (!rst_req && lat < SETTLE) begin
            @(posedge i_clk);
            lat++;
        end
        check(lat >= DET && lat <= DET + 10, 1);
        axi_rd(CTRL, 32'hc7, OK);
        axi_rd(STAT, 32'h5, OK);
        check(nmi_cnt, k);
        supply(HI, SETTLE);
        check(rst_req, 0);
        axi_wr(CLR, 32'h7, OK);
        axi_rd(STAT, 32'h0, OK);
        for (int s = 0; s < 2; s++) begin
            c = 32'h27 | (s << 4);
            axi_wr(CTRL, c, OK);
            axi_wr(ENA, 32'h3, OK);
            k = nmi_cnt;
            supply(LO, SETTLE);
            check(nmi_cnt, k + 1);
            check(irq, 1);
            axi_rd(CTRL, c | 32'h80, OK);
            supply(HI, SETTLE);
            check(nmi_cnt, k + 1 + s);
            check(rst_req, 0);
            axi_wr(ENA, 32'h0, OK);
            check(irq, 0);
            axi_wr(ENA, 32'h3, OK);
            check(irq, 1);
            axi_wr(CLR, 32'h3, OK);
            check(irq, 0);
            axi_rd(STAT, 32'h0, OK);
        end
        k = nmi_cnt;
        repeat (40) begin
            r = rnd();
            supply(r[0] ? LO : HI, int'(r[9:4]) + 1);
        end
        supply(HI, SETTLE);
        check(nmi_cnt, k);
        check(long_cnt, 0);
        wrap_up();
    end
endmodule

`default_nettype wire
